// File: src/supervisor_defines.svh
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH
`define CLOCK_HZ 50000000
`define HOLD_MS 200
`define WDOG_MS 1600
`define WRITE_MS 5
`define GLITCH_NS 30
`define TICK_CYCLES (`CLOCK_HZ / 1000)
`define GLITCH_CYCLES ((`GLITCH_NS * 50 + 999) / 1000 + 1)
`endif

// File: src/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;
	typedef enum logic [1:0] {
		SUP_POWERED_DOWN,
		SUP_HOLDING,
		SUP_RUNNING
	} sup_state_e;
	typedef enum logic [1:0] {
		MEM_IDLE,
		MEM_ACCESS,
		MEM_WRITING
	} mem_state_e;
	typedef struct packed {
		logic active_high_out;
		logic active_low_oe;
		logic aux_low_oe;
	} reset_pins_s;
	typedef struct packed {
		logic enable;
		logic abort;
		logic write_launch_ok;
	} mem_gate_s;
endpackage
`default_nettype wire

// File: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with glitch filter on the settled side
module pin_sync #(
	parameter int FILTER = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic enable,
	input wire logic raw,
	output logic filtered
);
	logic meta;
	logic settled;
	logic [7:0] run;
	logic [7:0] next_run;
	logic next_filtered;
	always_comb begin
		next_run = run;
		next_filtered = filtered;
		if (settled == filtered) begin
			next_run = 8'h00;
		end else if (run >= 8'(FILTER - 1)) begin
			next_run = 8'h00;
			next_filtered = settled;
		end else begin
			next_run = run + 8'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			meta <= 1'h1;
			settled <= 1'h1;
			run <= 8'h00;
			filtered <= 1'h1;
		end else if (enable) begin
			meta <= raw;
			settled <= meta;
			run <= next_run;
			filtered <= next_filtered;
		end
	end
endmodule
`default_nettype wire

// File: src/supply_supervisor_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
module supply_supervisor_watchdog #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter bit WATCHDOG_PRESENT = 1'h1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable,
	input wire logic supply_ok,
	input wire logic aux_sense_input,
	input wire logic watchdog_toggle_input,
	input wire logic reset_pin_in,
	input wire logic mem_request,
	input wire logic mem_write_request,
	output logic reset_high_out,
	output logic reset_low_oe,
	output logic aux_low_flag_oe,
	output logic mem_enable,
	output logic mem_abort,
	output logic mem_busy,
	output logic mem_write_done
);
	localparam logic [15:0] HOLD_TICKS = 16'(`HOLD_MS);
	localparam logic [15:0] WDOG_TICKS = 16'(`WDOG_MS);
	localparam logic [15:0] WRITE_TICKS = 16'(`WRITE_MS);

	// reset stays asserted in every state but the running one
	function automatic logic holds_reset(input supervisor_pkg::sup_state_e s);
		holds_reset = (s != supervisor_pkg::SUP_RUNNING);
	endfunction
	// all timers here step by one millisecond tick
	function automatic logic [15:0] inc16(input logic [15:0] value);
		inc16 = value + 16'h0001;
	endfunction

	logic supply_f;
	logic aux_f;
	logic wdi_f;
	logic pin_f;
	// supply glitch rejection: 30 ns rounded up to whole cycles, plus one cycle
	pin_sync #(.FILTER(`GLITCH_CYCLES)) u_supply (
		.clock(clock), .rst(rst), .enable(clock_enable),
		.raw(supply_ok), .filtered(supply_f));
	pin_sync #(.FILTER(1)) u_aux (
		.clock(clock), .rst(rst), .enable(clock_enable),
		.raw(aux_sense_input), .filtered(aux_f));
	pin_sync #(.FILTER(1)) u_wdi (
		.clock(clock), .rst(rst), .enable(clock_enable),
		.raw(watchdog_toggle_input), .filtered(wdi_f));
	pin_sync #(.FILTER(1)) u_pin (
		.clock(clock), .rst(rst), .enable(clock_enable),
		.raw(reset_pin_in), .filtered(pin_f));

	// shared timebase: one pulse each millisecond
	logic [31:0] tick_count;
	logic [31:0] next_tick_count;
	logic tick;
	assign tick = (tick_count == 32'(TICK_CYCLES - 1));
	always_comb begin
		next_tick_count = tick ? 32'h00000000 : tick_count + 32'h00000001;
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			tick_count <= 32'h00000000;
		end else if (clock_enable) begin
			tick_count <= next_tick_count;
		end
	end

	// edge memory for pin and watchdog input
	logic pin_prev;
	logic wdi_prev;
	logic pin_fall;
	logic wdi_edge;
	// our own drive of the pin must not read back as a manual reset
	assign pin_fall = pin_prev & ~pin_f & ~reset_low_oe;
	assign wdi_edge = wdi_prev ^ wdi_f;
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_prev <= 1'h1;
			wdi_prev <= 1'h1;
		end else if (clock_enable) begin
			pin_prev <= pin_f;
			wdi_prev <= wdi_f;
		end
	end

	// watchdog counter
	logic [15:0] wdog_count;
	logic [15:0] next_wdog_count;
	logic wdog_expired;
	logic reset_active;
	logic next_reset_active;
	assign wdog_expired = WATCHDOG_PRESENT && (wdog_count >= WDOG_TICKS);
	always_comb begin
		next_wdog_count = wdog_count;
		if (!WATCHDOG_PRESENT || reset_active || wdi_edge) begin
			next_wdog_count = 16'h0000;
		end else if (tick && !wdog_expired) begin
			next_wdog_count = inc16(wdog_count);
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			wdog_count <= 16'h0000;
		end else if (clock_enable) begin
			wdog_count <= next_wdog_count;
		end
	end

	// reset state machine
	supervisor_pkg::sup_state_e state;
	supervisor_pkg::sup_state_e next_state;
	logic [15:0] hold_count;
	logic [15:0] next_hold_count;
	supervisor_pkg::reset_pins_s pins;
	supervisor_pkg::reset_pins_s next_pins;
	assign reset_active = holds_reset(state);
	always_comb begin
		next_state = state;
		next_hold_count = hold_count;
		case (state)
			supervisor_pkg::SUP_POWERED_DOWN: begin
				next_hold_count = 16'h0000;
				if (supply_f) begin
					next_state = supervisor_pkg::SUP_HOLDING;
				end
			end
			supervisor_pkg::SUP_HOLDING: begin
				if (!supply_f) begin
					next_state = supervisor_pkg::SUP_POWERED_DOWN;
				end else if (pin_fall) begin
					next_hold_count = 16'h0000;
				end else if (hold_count >= HOLD_TICKS) begin
					next_state = supervisor_pkg::SUP_RUNNING;
				end else if (tick) begin
					next_hold_count = inc16(hold_count);
				end
			end
			supervisor_pkg::SUP_RUNNING: begin
				next_hold_count = 16'h0000;
				if (!supply_f) begin
					next_state = supervisor_pkg::SUP_POWERED_DOWN;
				end else if (pin_fall || wdog_expired) begin
					next_state = supervisor_pkg::SUP_HOLDING;
				end
			end
			default: begin
				next_state = supervisor_pkg::SUP_POWERED_DOWN;
			end
		endcase
		// both polarities from the one reset state
		next_pins.active_high_out = holds_reset(next_state);
		next_pins.active_low_oe = holds_reset(next_state);
		next_pins.aux_low_oe = ~aux_f;
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= supervisor_pkg::SUP_POWERED_DOWN;
			hold_count <= 16'h0000;
			pins <= 3'h6;
		end else if (clock_enable) begin
			state <= next_state;
			hold_count <= next_hold_count;
			pins <= next_pins;
		end
	end
	assign reset_high_out = pins.active_high_out;
	assign reset_low_oe = pins.active_low_oe;
	assign aux_low_flag_oe = pins.aux_low_oe;
	// reset level that the outputs take at the coming edge
	assign next_reset_active = holds_reset(next_state);

	// memory gating; the write timer survives reset so a started write finishes
	supervisor_pkg::mem_state_e mem_state;
	supervisor_pkg::mem_state_e next_mem_state;
	logic [15:0] write_count;
	logic [15:0] next_write_count;
	supervisor_pkg::mem_gate_s gate;
	supervisor_pkg::mem_gate_s next_gate;
	logic next_busy;
	logic next_done;
	always_comb begin
		next_mem_state = mem_state;
		next_write_count = write_count;
		next_done = 1'h0;
		next_gate.abort = 1'h0;
		case (mem_state)
			supervisor_pkg::MEM_IDLE: begin
				if (!reset_active && mem_request) begin
					next_mem_state = supervisor_pkg::MEM_ACCESS;
				end
			end
			supervisor_pkg::MEM_ACCESS: begin
				if (reset_active) begin
					next_mem_state = supervisor_pkg::MEM_IDLE;
					next_gate.abort = 1'h1;
				end else if (mem_write_request && !next_reset_active) begin
					next_mem_state = supervisor_pkg::MEM_WRITING;
					next_write_count = 16'h0000;
				end else if (!mem_request) begin
					next_mem_state = supervisor_pkg::MEM_IDLE;
				end
			end
			supervisor_pkg::MEM_WRITING: begin
				if (write_count >= WRITE_TICKS) begin
					next_mem_state = supervisor_pkg::MEM_IDLE;
					next_done = 1'h1;
				end else if (tick) begin
					next_write_count = inc16(write_count);
				end
			end
			default: begin
				next_mem_state = supervisor_pkg::MEM_IDLE;
			end
		endcase
		// enable falls at the same edge as the reset outputs, never one cycle later
		next_gate.enable = !next_reset_active
			&& (next_mem_state == supervisor_pkg::MEM_ACCESS);
		next_gate.write_launch_ok = !next_reset_active;
		next_busy = (next_mem_state == supervisor_pkg::MEM_WRITING);
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			mem_state <= supervisor_pkg::MEM_IDLE;
			write_count <= 16'h0000;
			gate <= 3'h0;
			mem_busy <= 1'h0;
			mem_write_done <= 1'h0;
		end else if (clock_enable) begin
			mem_state <= next_mem_state;
			write_count <= next_write_count;
			gate <= next_gate;
			mem_busy <= next_busy;
			mem_write_done <= next_done;
		end
	end
	assign mem_enable = gate.enable;
	assign mem_abort = gate.abort;

	// all checks run on the design clock and rest while rst is high
	chk_outputs_paired: assert property (@(posedge clock) disable iff (rst)
		reset_high_out == reset_low_oe) else $error("reset polarities differ");
	chk_aux_follows: assert property (@(posedge clock) disable iff (rst)
		clock_enable && $past(clock_enable) |-> aux_low_flag_oe == ~$past(aux_f))
		else $error("aux flag wrong");
	chk_mem_blocked: assert property (@(posedge clock) disable iff (rst)
		reset_low_oe |-> !mem_enable) else $error("memory enabled in reset");
	chk_abort_on_reset: assert property (@(posedge clock) disable iff (rst)
		clock_enable && mem_state == supervisor_pkg::MEM_ACCESS && reset_active
		|=> mem_abort) else $error("no abort");
	chk_abort_pulse: assert property (@(posedge clock) disable iff (rst)
		clock_enable && mem_abort |=> !mem_abort)
		else $error("abort longer than one cycle");
	chk_refuse_new: assert property (@(posedge clock) disable iff (rst)
		clock_enable && mem_state == supervisor_pkg::MEM_IDLE && reset_active
		|=> mem_state == supervisor_pkg::MEM_IDLE) else $error("access opened in reset");
	chk_write_kept: assert property (@(posedge clock) disable iff (rst)
		mem_state == supervisor_pkg::MEM_WRITING && write_count < WRITE_TICKS
		|=> mem_state == supervisor_pkg::MEM_WRITING) else $error("write aborted");
	chk_launch_gated: assert property (@(posedge clock) disable iff (rst)
		$rose(mem_busy) |-> gate.write_launch_ok && !reset_low_oe)
		else $error("write launched in reset");
	chk_done_pulse: assert property (@(posedge clock) disable iff (rst)
		clock_enable && mem_write_done |=> !mem_write_done)
		else $error("done longer than one cycle");
	chk_wdog_cleared: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reset_active |=> wdog_count == 16'h0000)
		else $error("watchdog counts in reset");
	chk_wdog_edge: assert property (@(posedge clock) disable iff (rst)
		clock_enable && wdi_edge |=> wdog_count == 16'h0000)
		else $error("edge did not clear");
	chk_supply_drop: assert property (@(posedge clock) disable iff (rst)
		clock_enable && !supply_f |=> reset_low_oe) else $error("no reset on low supply");
	chk_hold_full: assert property (@(posedge clock) disable iff (rst)
		$rose(state == supervisor_pkg::SUP_RUNNING) |-> $past(hold_count) >= HOLD_TICKS)
		else $error("hold too short");
	chk_release_due: assert property (@(posedge clock) disable iff (rst)
		clock_enable && state == supervisor_pkg::SUP_HOLDING && supply_f && !pin_fall
		&& hold_count >= HOLD_TICKS |=> !reset_low_oe) else $error("reset not released");
	chk_wdog_fires: assert property (@(posedge clock) disable iff (rst)
		clock_enable && wdog_expired && supply_f && state == supervisor_pkg::SUP_RUNNING
		|=> state == supervisor_pkg::SUP_HOLDING) else $error("watchdog missed");
endmodule
`default_nettype wire

// File: bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: reset pin wire with pull-up, periodic watchdog toggling
module host_model #(
	parameter int KICK_CYCLES = 100
) (
	input wire logic clock,
	input wire logic reset_low_oe,
	input wire logic pull_low,
	input wire logic kick_en,
	output logic reset_pin,
	output logic toggle
);
	int count = 0;
	logic level = 1'h0;
	assign toggle = level;
	// pull-up wins only while nobody drives low
	assign reset_pin = !(reset_low_oe || pull_low);
	always @(negedge clock) begin
		if (kick_en) begin
			count <= (count == KICK_CYCLES - 1) ? 0 : count + 1;
			if (count == KICK_CYCLES - 1) level <= !level;
		end
	end
endmodule
`default_nettype wire

// File: bench/supply_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
	typedef struct {logic aux; logic flag;} row_s;
	logic clock = 1'h0, rst = 1'h1, supply_ok = 1'h0, aux = 1'h1;
	logic mem_req = 1'h0, mem_wr = 1'h0, pull = 1'h0, kick = 1'h0, ce = 1'h1;
	logic pin, tog, rh, rl, af, me, ma, mb, md;
	int err_count = 0, n_tests = 0, cyc = 0, n = 0;
	logic abort_seen = 1'h0, done_seen = 1'h0;
	row_s rows [3] = '{'{1'h1, 1'h0}, '{1'h0, 1'h1}, '{1'h1, 1'h0}};
	supply_supervisor_watchdog #(.TICK_CYCLES(4)) i_supply_supervisor_watchdog (
		.clock(clock), .rst(rst), .clock_enable(ce), .supply_ok(supply_ok),
		.aux_sense_input(aux), .watchdog_toggle_input(tog), .reset_pin_in(pin),
		.mem_request(mem_req), .mem_write_request(mem_wr), .reset_high_out(rh),
		.reset_low_oe(rl), .aux_low_flag_oe(af), .mem_enable(me), .mem_abort(ma),
		.mem_busy(mb), .mem_write_done(md)
	);
	host_model i_host_model (.clock(clock), .reset_low_oe(rl), .pull_low(pull),
		.kick_en(kick), .reset_pin(pin), .toggle(tog));
	initial forever #10 clock = ~clock;
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ceiling sits well above the sum of all hold and watchdog waits
	always @(posedge clock) begin
		cyc++;
		if (ma === 1'h1) abort_seen = 1'h1;
		if (md === 1'h1) done_seen = 1'h1;
		if (cyc == 32000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task check(input logic seen, input logic exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task cycles(input int k);
		repeat (k) @(negedge clock);
	endtask
	task wait_rst(input logic v, input int max);
		n = 0;
		while (rh !== v && n < max) begin
			@(negedge clock);
			n++;
		end
	endtask
	task finished(input string s);
		$display("test %s done", s);
	endtask
	initial begin
		cycles(10);
		rst = 1'h0;
		cycles(1);
		check(rh, 1'h1);
		check(rl, 1'h1);
		check(me, 1'h0);
		finished("reset");
		foreach (rows[i]) begin
			aux = rows[i].aux;
			cycles(4);
			check(af, rows[i].flag);
		end
		finished("aux flag");
		kick = 1'h1;
		mem_req = 1'h1;
		supply_ok = 1'h1;
		cycles(700);
		check(rh, 1'h1);
		check(me, 1'h0);
		wait_rst(1'h0, 200);
		check(n >= 96 && n <= 125, 1'h1);
		check(rl, 1'h0);
		cycles(2);
		check(me, 1'h1);
		finished("power up");
		mem_wr = 1'h1;
		cycles(1);
		mem_wr = 1'h0;
		cycles(1);
		check(mb, 1'h1);
		supply_ok = 1'h0;
		cycles(12);
		check(rh, 1'h1);
		check(me, 1'h0);
		// the memory was writing, not in an open access, so nothing is aborted
		check(abort_seen, 1'h0);
		check(mb, 1'h1);
		// a launch attempt held through reset must stay refused
		mem_wr = 1'h1;
		n = 0;
		while (done_seen !== 1'h1 && n < 40) begin
			cycles(1);
			n++;
		end
		check(done_seen, 1'h1);
		cycles(2);
		check(mb, 1'h0);
		mem_wr = 1'h0;
		finished("memory");
		supply_ok = 1'h1;
		wait_rst(1'h0, 900);
		supply_ok = 1'h0;
		cycles(1);
		supply_ok = 1'h1;
		cycles(12);
		check(rh, 1'h0);
		finished("glitch");
		abort_seen = 1'h0;
		// long enough that the device drives the pin before the host lets go
		pull = 1'h1;
		cycles(10);
		pull = 1'h0;
		wait_rst(1'h1, 10);
		check(rh, 1'h1);
		check(abort_seen, 1'h1);
		check(me, 1'h0);
		wait_rst(1'h0, 900);
		check(n >= 785 && n <= 812, 1'h1);
		finished("manual");
		wait_rst(1'h1, 7000);
		check(n == 7000, 1'h1);
		kick = 1'h0;
		wait_rst(1'h1, 6500);
		check(n >= 6280 && n <= 6420, 1'h1);
		wait_rst(1'h0, 900);
		wait_rst(1'h1, 6500);
		check(n >= 6390 && n <= 6420, 1'h1);
		finished("watchdog");
		// a frozen clock enable stretches the hold by the frozen time
		ce = 1'h0;
		cycles(900);
		check(rh, 1'h1);
		ce = 1'h1;
		wait_rst(1'h0, 900);
		check(n >= 790 && n <= 805, 1'h1);
		finished("clock enable");
		tally_and_finish();
	end
endmodule
`default_nettype wire
